// File: hdl/sesr_pkg.sv
package sesr_pkg;

  // ****************************************************************
  // Event bit positions, shared by the flag and mask registers, and the summary bit position
  // ****************************************************************
  localparam int unsigned BIT_OP_DONE = 0;
  localparam int unsigned BIT_QRY_ERR = 2;
  localparam int unsigned BIT_DEV_ERR = 3;
  localparam int unsigned BIT_EXE_ERR = 4;
  localparam int unsigned BIT_CMD_ERR = 5;
  localparam int unsigned STB_SUMMARY_BIT = 5;

  // Flag positions that may ever hold a one
  localparam logic [7:0] USED_MASK = 8'h3d;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ****************************************************************
  // Error class codes (hundreds digit of an error number)
  // ****************************************************************
  localparam logic [2:0] CLASS_CMD = 3'h1;
  localparam logic [2:0] CLASS_EXE = 3'h2;
  localparam logic [2:0] CLASS_DEV = 3'h3;
  localparam logic [2:0] CLASS_QRY = 3'h4;

  // Operation-complete tracking, Gray coded along idle-wait-report
  typedef enum logic [1:0]
  {
    SESR_OPC_IDLE = 2'b00,
    SESR_OPC_WAIT = 2'b01,
    SESR_OPC_DONE = 2'b11
  } sesr_opc_e;

endpackage : sesr_pkg

// File: hdl/sesr_event_status.sv
// What this block does
// - Clear-status empties errors and event registers, keeps the mask
// - Clear-status idles both completion trackers
// - Mask load takes 0..255, resets to zero
// - Summary bit 5 is OR of masked flags
// - Mask query returns mask, changes nothing
// - Flags and mask share one bit layout
// - Mask one passes event, zero blocks it
// - Flag query returns flags then clears them
// - Error class picks flag bit 5..2
// - Completion flag set only when work idle
module sesr_event_status
  import sesr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CLS_I,
  input wire logic MASK_WR_I,
  input wire logic [7:0] MASK_DATA_I,
  input wire logic MASK_RD_I,
  input wire logic FLAGS_RD_I,
  input wire logic ERR_VALID_I,
  input wire logic [2:0] ERR_CLASS_I,
  input wire logic OPC_CMD_I,
  input wire logic OPC_QRY_I,
  input wire logic BUSY_I,
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic ESB_O,
  output logic OPC_QRY_REPLY_O,
  output logic ERRQ_CLEAR_O,
  output logic EVENTS_CLEAR_O
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Error class to the flag bit it raises; other classes raise none
  function automatic logic [7:0] class_to_flag(input logic [2:0] cls);
    logic [7:0] f;
    f = 8'h00;
    case (cls)
      CLASS_CMD: f[BIT_CMD_ERR] = 1'b1;
      CLASS_EXE: f[BIT_EXE_ERR] = 1'b1;
      CLASS_DEV: f[BIT_DEV_ERR] = 1'b1;
      CLASS_QRY: f[BIT_QRY_ERR] = 1'b1;
      default: f = 8'h00;
    endcase
    return f;
  endfunction : class_to_flag

  // Summary of the flags that the mask lets through
  function automatic logic summary_of(input logic [7:0] flags,
                                      input logic [7:0] mask);
    return |(flags & mask);
  endfunction : summary_of

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] event_enable_mask_reg;
  logic [7:0] mask_next;
  logic [7:0] standard_event_flags_reg;
  logic [7:0] flags_next;
  logic [7:0] set_bits;
  sesr_opc_e opc_cmd_reg;
  sesr_opc_e opc_qry_reg;
  logic opc_set;

  // ****************************************************************
  // Operation-complete command tracker
  // ****************************************************************
  // Commands keep flowing while waiting; only the flag is deferred
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I || CLS_I)
      opc_cmd_reg <= SESR_OPC_IDLE;
    else
    begin
      case (opc_cmd_reg)
        SESR_OPC_IDLE:
          if (OPC_CMD_I)
            opc_cmd_reg <= SESR_OPC_WAIT;
        SESR_OPC_WAIT:
          if (!OPC_CMD_I && !BUSY_I)
            opc_cmd_reg <= SESR_OPC_IDLE;
        default:
          opc_cmd_reg <= OPC_CMD_I ? SESR_OPC_WAIT : SESR_OPC_IDLE;
      endcase
    end
  end

  // Clear-status in the same cycle cancels a pending completion report
  assign opc_set = (opc_cmd_reg == SESR_OPC_WAIT) && !BUSY_I && !CLS_I;

  // ****************************************************************
  // Operation-complete query tracker
  // ****************************************************************
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I || CLS_I)
    begin
      opc_qry_reg <= SESR_OPC_IDLE;
      OPC_QRY_REPLY_O <= 1'b0;
    end
    else
    begin
      OPC_QRY_REPLY_O <= 1'b0;
      case (opc_qry_reg)
        SESR_OPC_IDLE:
          if (OPC_QRY_I)
            opc_qry_reg <= SESR_OPC_WAIT;
        SESR_OPC_WAIT:
          if (!BUSY_I)
            opc_qry_reg <= SESR_OPC_DONE;
        SESR_OPC_DONE:
        begin
          OPC_QRY_REPLY_O <= 1'b1;
          opc_qry_reg <= SESR_OPC_IDLE;
        end
        default: opc_qry_reg <= SESR_OPC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************
  always_comb
  begin
    set_bits = 8'h00;
    if (ERR_VALID_I)
      set_bits = class_to_flag(ERR_CLASS_I);
    if (opc_set)
      set_bits[BIT_OP_DONE] = 1'b1;
    // Read-clear or clear-status loses to a same-cycle event
    if (CLS_I || FLAGS_RD_I)
      flags_next = set_bits;
    else
      flags_next = standard_event_flags_reg | set_bits;
    flags_next = flags_next & USED_MASK;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      standard_event_flags_reg <= FLAGS_RESET;
    else
      standard_event_flags_reg <= flags_next;
  end

  // ****************************************************************
  // Enable mask, untouched by clear-status
  // ****************************************************************
  // Next mask is shared by the register and the summary, so a load
  // and an event in one cycle are summarised together
  always_comb
  begin
    mask_next = event_enable_mask_reg;
    if (MASK_WR_I)
      mask_next = MASK_DATA_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      event_enable_mask_reg <= MASK_RESET;
    else
      event_enable_mask_reg <= mask_next;
  end

  // ****************************************************************
  // Query answers and summary
  // ****************************************************************
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      RD_DATA_O <= 8'h00;
      RD_VALID_O <= 1'b0;
    end
    else
    begin
      // Flags win when both queries meet; the answer then holds
      // until the next query so a slow reader still sees it
      RD_VALID_O <= FLAGS_RD_I || MASK_RD_I;
      if (FLAGS_RD_I)
        RD_DATA_O <= standard_event_flags_reg;
      else if (MASK_RD_I)
        RD_DATA_O <= event_enable_mask_reg;
    end
  end

  // Summary registered from next state so it tracks the flags exactly
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      ESB_O <= 1'b0;
    else
      ESB_O <= summary_of(flags_next, mask_next);
  end

  // Pulses telling the error queue and the other event registers to clear
  // Those registers live outside this block; one pulse per clear-status
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      ERRQ_CLEAR_O <= 1'b0;
      EVENTS_CLEAR_O <= 1'b0;
    end
    else
    begin
      ERRQ_CLEAR_O <= CLS_I;
      EVENTS_CLEAR_O <= CLS_I;
    end
  end

endmodule : sesr_event_status

// File: verif/sesr_busy_model.sv
module sesr_busy_model
(
  input wire logic CLK_I,
  input wire logic go_i,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // Earlier work keeps the unit busy a while
  always_ff @(posedge CLK_I)
  begin
    cnt <= go_i ? 6 : (cnt > 0 ? cnt - 1 : 0);
  end
  assign busy_o = cnt > 0;
endmodule : sesr_busy_model

// File: verif/sesr_event_status_chk.sv
module sesr_event_status_chk
(
  input wire logic CLK_I, RESETN_I, CLS_I, MASK_WR_I, MASK_RD_I,
  input wire logic FLAGS_RD_I, BUSY_I, RD_VALID_O, ESB_O,
  input wire logic [7:0] MASK_DATA_I, RD_DATA_O,
  input wire logic OPC_QRY_REPLY_O, ERRQ_CLEAR_O, EVENTS_CLEAR_O
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  sequence clr_pulse;
    ERRQ_CLEAR_O && EVENTS_CLEAR_O ##1 !ERRQ_CLEAR_O;
  endsequence
  cls_clears_a: assert property (CLS_I ##1 !CLS_I |-> clr_pulse)
    else $error("clear pulse wrong");
  clear_cause_a: assert property (EVENTS_CLEAR_O |-> $past(CLS_I))
    else $error("clear without command");
  read_answer_a: assert property (MASK_RD_I |=> RD_VALID_O)
    else $error("no answer");
  read_cause_a: assert property (RD_VALID_O |->
    $past(MASK_RD_I) || $past(FLAGS_RD_I)) else $error("stray answer");
  unused_zero_a: assert property (RD_VALID_O && $past(FLAGS_RD_I)
    |-> (RD_DATA_O & 8'hc2) == 8'h00) else $error("unused bit set");
  mask_block_a: assert property (MASK_WR_I &&
    MASK_DATA_I == 8'h00 |=> !ESB_O) else $error("summary not blocked");
  reply_wait_a: assert property (OPC_QRY_REPLY_O |->
    !$past(BUSY_I, 2)) else $error("reply while busy");
  reply_pulse_a: assert property (OPC_QRY_REPLY_O
    |=> !OPC_QRY_REPLY_O) else $error("reply too long");
endmodule : sesr_event_status_chk
bind sesr_event_status sesr_event_status_chk i_chk (.*);

// File: verif/tb_standard_event_status_reporting.sv
module tb_standard_event_status_reporting;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_I = 0, RESETN_I = 0, go, CLS_I, MASK_WR_I, MASK_RD_I;
  logic FLAGS_RD_I, ERR_VALID_I, OPC_CMD_I, OPC_QRY_I, BUSY_I;
  logic RD_VALID_O, ESB_O, OPC_QRY_REPLY_O, ERRQ_CLEAR_O, EVENTS_CLEAR_O;
  logic [7:0] st = 8'h00, MASK_DATA_I = 8'h00, RD_DATA_O, rep = 8'h00;
  logic [2:0] ERR_CLASS_I;
  int mismatches = 0, n_checks = 0;
  assign {go, CLS_I, MASK_WR_I, MASK_RD_I, FLAGS_RD_I, ERR_VALID_I,
    OPC_CMD_I, OPC_QRY_I} = st;
  assign ERR_CLASS_I = MASK_DATA_I[2:0];
  sesr_event_status i_sesr_event_status (.*);
  sesr_busy_model u_busy (.CLK_I(CLK_I), .go_i(go), .busy_o(BUSY_I));
  initial forever #20 CLK_I = ~CLK_I;
  always @(posedge CLK_I) rep <= rep + {7'h00, OPC_QRY_REPLY_O};
  // ****
  // Tasks
  // ****
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  // Strobes stand one edge, so a call is never re-entered in one step
  task cmd(input logic [7:0] s, input logic [7:0] d);
    @(posedge CLK_I);
    st <= s;
    MASK_DATA_I <= d;
    @(posedge CLK_I);
    st <= 8'h00;
  endtask : cmd
  task rd(input logic [7:0] s, input logic [7:0] e);
    cmd(s, 8'h00);
    #1 chk(e, RD_DATA_O);
    chk(8'h01, {7'h00, RD_VALID_O});
  endtask : rd
  initial
  begin
    repeat (2) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    rd(8'h10, 8'h00);
    cmd(8'h20, 8'hff);
    rd(8'h10, 8'hff);
    for (int c = 0; c < 8; c++)
    begin
      cmd(8'h04, c[7:0]);
      #1 chk(8'(c inside {[1:4]}), {7'h00, ESB_O});
      rd(8'h08, c inside {[1:4]} ? 8'h40 >> c : 8'h00);
    end
    cmd(8'h20, 8'hdf);
    cmd(8'h04, 8'h01);
    #1 chk(8'h00, {7'h00, ESB_O});
    rd(8'h10, 8'hdf);
    rd(8'h08, 8'h20);
    rd(8'h08, 8'h00);
    cmd(8'h82, 8'h00);
    rd(8'h08, 8'h00);
    repeat (8) @(posedge CLK_I);
    rd(8'h08, 8'h01);
    cmd(8'h81, 8'h00);
    repeat (10) @(posedge CLK_I);
    chk(8'h01, rep);
    cmd(8'h87, 8'h02);
    cmd(8'h40, 8'h00);
    #1 chk(8'h03, {5'h00, ESB_O, ERRQ_CLEAR_O, EVENTS_CLEAR_O});
    repeat (10) @(posedge CLK_I);
    chk(8'h01, rep);
    rd(8'h08, 8'h00);
    rd(8'h10, 8'hdf);
    cmd(8'h24, 8'h01);
    #1 chk(8'h00, {7'h00, ESB_O});
    summarize();
  end
  initial
  begin
    #20000 mismatches++;
    summarize();
  end
endmodule : tb_standard_event_status_reporting
